// ===== inc/psic_pkg.sv
// constants for the strap decode and sync clock logic
package psic_pkg;
  localparam int MV_W = 13;
  localparam int KHZ_W = 11;
  localparam int DEG_W = 9;
  localparam int CYC_W = 12;
  localparam int BAND_W = 5;
  // reference clock rate
  localparam int CLK_KHZ = 125000;
  localparam int CLK_PERIOD_PS = 8000;
  // accepted programmed voltage window
  localparam logic [MV_W-1:0] VOUT_MIN_MV = 13'h01F4;
  localparam logic [MV_W-1:0] VOUT_MAX_MV = 13'h1482;
  // frequency window and open-strap fallback
  localparam logic [KHZ_W-1:0] FREQ_MIN_KHZ = 11'h12C;
  localparam logic [KHZ_W-1:0] FREQ_MAX_KHZ = 11'h3E8;
  localparam logic [KHZ_W-1:0] FREQ_FALLBACK_KHZ = 11'h23F;
  localparam logic [KHZ_W-1:0] FREQ_STEP_KHZ = 11'h032;
  localparam logic [BAND_W-1:0] SYNC_TOP_BAND = 5'h10;
  // sync period limits and loss timeout
  localparam int SYNC_FAST_PERIOD_NS = 1000;
  localparam int SYNC_TIMEOUT_NS = 6667;
  localparam logic [CYC_W-1:0] PER_MIN_CYC =
    CYC_W'((SYNC_FAST_PERIOD_NS * 1000) / CLK_PERIOD_PS - 1);
  localparam logic [CYC_W-1:0] SYNC_TIMEOUT_CYC =
    CYC_W'((SYNC_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // output-level strap bands, millivolts; band 0 is track mode
  localparam logic [BAND_W-1:0] SET_TRACK_BAND = 5'h00;
  localparam logic [BAND_W-1:0] SET_BANDS = 5'h12;
  localparam logic [MV_W-1:0] SET_MV [0:17] = '{
    13'h0000, 13'h0258, 13'h02BC, 13'h02EE, 13'h0320, 13'h0352,
    13'h0384, 13'h03B6, 13'h03E8, 13'h041A, 13'h044C, 13'h04B0,
    13'h05DC, 13'h0708, 13'h09C4, 13'h0CE4, 13'h1388, 13'h0000};
  // address strap decode
  localparam logic [7:0] ADDR_BASE = 8'h0A;
  localparam logic [7:0] ADDR_COL_STEP = 8'h18;
  localparam logic [7:0] ADDR_MAX = 8'h7F;
  localparam logic [2:0] ADDR_HIGH_TOP = 3'h4;
  localparam logic [4:0] GAIN_STEP_MOHM = 5'h04;
  // divider ranges: upper end of each, millivolts
  localparam logic [MV_W-1:0] DIV_UPPER_MV [0:2] = '{13'h0528, 13'h0A50, 13'h1482};
  localparam logic [DEG_W-1:0] FULL_TURN_DEG = 9'h168;
  localparam logic [DEG_W-1:0] PHASE_DEG [0:7] = '{
    9'h000, 9'h03C, 9'h078, 9'h0B4, 9'h0F0, 9'h12C, 9'h05A, 9'h10E};
endpackage : psic_pkg

// ===== hdl/psic_config_core.sv
// strap decode, switching frequency, sync lock and interleave timing
`timescale 1ns/10ps
module psic_config_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic strap_ready,
  input wire logic [psic_pkg::BAND_W-1:0] set_band,
  input wire logic set_open,
  input wire logic [psic_pkg::BAND_W-1:0] sync_band,
  input wire logic sync_open,
  input wire logic [4:0] address_strap_low,
  input wire logic [2:0] address_strap_high,
  input wire logic sync_pin,
  input wire logic enable_pin,
  input wire logic vout_wr,
  input wire logic [psic_pkg::MV_W-1:0] vout_wr_mv,
  input wire logic freq_wr,
  input wire logic [psic_pkg::KHZ_W-1:0] freq_wr_khz,
  input wire logic interleave_wr,
  input wire logic [psic_pkg::DEG_W-1:0] interleave_wr_deg,
  output logic config_done,
  output logic track_mode,
  output logic set_fault,
  output logic sync_fault,
  output logic freq_valid,
  output logic [psic_pkg::MV_W-1:0] vout_target_mv,
  output logic [1:0] output_divider_range,
  output logic [psic_pkg::KHZ_W-1:0] freq_khz,
  output logic [6:0] bus_address,
  output logic [4:0] current_sense_gain,
  output logic [psic_pkg::DEG_W-1:0] phase_deg,
  output logic sync_locked,
  output logic pwm_center
);
  import psic_pkg::*;

  typedef struct packed {
    logic sync_m;
    logic sync_s;
    logic sync_d;
    logic en_m;
    logic en_s;
    logic en_d;
    logic done;
    logic track;
    logic set_fault;
    logic sync_fault;
    logic freq_valid;
    logic [MV_W-1:0] vout;
    logic [1:0] div_range;
    logic [KHZ_W-1:0] freq;
    logic [6:0] addr;
    logic [4:0] gain;
    logic [DEG_W-1:0] phase;
    logic [CYC_W-1:0] meas_cnt;
    logic [CYC_W-1:0] meas_per;
    logic armed;
    logic present;
    logic locked;
    logic [CYC_W-1:0] pwm_cnt;
    logic center;
  } psic_state_t;

  psic_state_t s_r;
  psic_state_t s_nxt;
  logic sync_rise;
  logic en_rise;
  logic [1:0] lim_range;
  logic [CYC_W-1:0] per;

  function automatic logic [KHZ_W-1:0] freq_of_band(input logic [BAND_W-1:0] b);
    if (b == '0 || b >= SYNC_TOP_BAND)
      return FREQ_FALLBACK_KHZ;
    return KHZ_W'(FREQ_MIN_KHZ + FREQ_STEP_KHZ * KHZ_W'(b - 5'h01));
  endfunction : freq_of_band

  function automatic logic [1:0] div_of_mv(input logic [MV_W-1:0] mv);
    if (mv <= DIV_UPPER_MV[0])
      return 2'h0;
    if (mv <= DIV_UPPER_MV[1])
      return 2'h1;
    return 2'h2;
  endfunction : div_of_mv

  // upper end plus one fifth
  function automatic logic [MV_W-1:0] limit_mv(input logic [1:0] r);
    logic [MV_W-1:0] up;
    up = DIV_UPPER_MV[(r > 2'h2) ? 2'h2 : r];
    return MV_W'(up + up / 13'h0005);
  endfunction : limit_mv

  function automatic logic [CYC_W-1:0] khz_to_cyc(input logic [KHZ_W-1:0] k);
    if (k == '0)
      return '0;
    return CYC_W'(CLK_KHZ / int'(k));
  endfunction : khz_to_cyc

  function automatic logic [KHZ_W-1:0] cyc_to_khz(input logic [CYC_W-1:0] c);
    if (c == '0)
      return '0;
    return KHZ_W'(CLK_KHZ / int'(c));
  endfunction : cyc_to_khz

  function automatic logic [CYC_W-1:0] phase_cyc(input logic [CYC_W-1:0] p,
                                                 input logic [DEG_W-1:0] d);
    logic [CYC_W+DEG_W-1:0] prod;
    prod = (CYC_W+DEG_W)'(p) * (CYC_W+DEG_W)'(d);
    return CYC_W'(prod / (CYC_W+DEG_W)'(FULL_TURN_DEG));
  endfunction : phase_cyc

  function automatic logic [6:0] addr_of(input logic [4:0] lo, input logic [2:0] hi);
    logic [7:0] sum;
    logic [2:0] h;
    h = (hi > ADDR_HIGH_TOP) ? ADDR_HIGH_TOP : hi;
    sum = 8'(ADDR_BASE + ADDR_COL_STEP * 8'(h) + 8'(lo));
    return 7'((sum > ADDR_MAX) ? ADDR_MAX : sum);
  endfunction : addr_of

  assign sync_rise = s_r.sync_s & ~s_r.sync_d;
  assign en_rise = s_r.en_s & ~s_r.en_d;
  // the range latches on the enable edge, so a write in that cycle uses it too
  assign lim_range = en_rise ? div_of_mv(s_r.vout) : s_r.div_range;
  assign per = s_r.locked ? s_r.meas_per : khz_to_cyc(s_r.freq);

  always_comb begin
    logic [2:0] hi;
    logic [6:0] ad;
    hi = (address_strap_high > ADDR_HIGH_TOP) ? ADDR_HIGH_TOP : address_strap_high;
    ad = addr_of(address_strap_low, address_strap_high);
    s_nxt = s_r;
    s_nxt.sync_m = sync_pin;
    s_nxt.sync_s = s_r.sync_m;
    s_nxt.sync_d = s_r.sync_s;
    s_nxt.en_m = enable_pin;
    s_nxt.en_s = s_r.en_m;
    s_nxt.en_d = s_r.en_s;
    // period measurement; too-fast edges are not taken as a clock
    if (sync_rise) begin
      s_nxt.meas_cnt = CYC_W'(1);
      s_nxt.meas_per = s_r.meas_cnt;
      s_nxt.present = s_r.armed && (s_r.meas_cnt >= PER_MIN_CYC);
      s_nxt.armed = 1'b1;
    end else if (s_r.meas_cnt >= SYNC_TIMEOUT_CYC) begin
      s_nxt.present = 1'b0;
      s_nxt.armed = 1'b0;
    end else begin
      s_nxt.meas_cnt = s_r.meas_cnt + CYC_W'(1);
    end
    // one-time strap capture
    if (!s_r.done && strap_ready) begin
      s_nxt.done = 1'b1;
      s_nxt.track = !set_open && (set_band == SET_TRACK_BAND);
      s_nxt.set_fault = set_open;
      s_nxt.vout = (set_open || set_band >= SET_BANDS) ? '0 : SET_MV[set_band];
      s_nxt.sync_fault = sync_open;
      if (s_r.present) begin
        s_nxt.freq = '0;
        s_nxt.freq_valid = 1'b0;
      end else begin
        s_nxt.freq = sync_open ? FREQ_FALLBACK_KHZ : freq_of_band(sync_band);
        s_nxt.freq_valid = 1'b1;
      end
      s_nxt.addr = ad;
      s_nxt.gain = 5'(GAIN_STEP_MOHM * 5'(hi + 3'h1));
      s_nxt.phase = PHASE_DEG[ad[2:0]];
    end
    if (en_rise) begin
      s_nxt.div_range = div_of_mv(s_r.vout);
      if (s_r.present) begin
        s_nxt.freq = cyc_to_khz(s_r.meas_per);
        s_nxt.freq_valid = 1'b1;
      end
    end
    // clock appearing later is followed only; stored value untouched
    s_nxt.locked = s_r.en_s && s_r.present;
    if (vout_wr && vout_wr_mv >= VOUT_MIN_MV && vout_wr_mv <= VOUT_MAX_MV) begin
      if (s_r.en_s && vout_wr_mv > limit_mv(lim_range))
        s_nxt.vout = limit_mv(lim_range);
      else
        s_nxt.vout = vout_wr_mv;
    end
    // crossing the 475 kHz boundary while on is left to the host
    if (freq_wr && freq_wr_khz >= FREQ_MIN_KHZ && freq_wr_khz <= FREQ_MAX_KHZ) begin
      s_nxt.freq = freq_wr_khz;
      s_nxt.freq_valid = 1'b1;
    end
    if (interleave_wr && !s_r.en_s && interleave_wr_deg < FULL_TURN_DEG)
      s_nxt.phase = interleave_wr_deg;
    // pwm period counter, restarted by each sync edge while locked
    if (!s_r.en_s || per == '0)
      s_nxt.pwm_cnt = '0;
    else if (s_r.locked && sync_rise)
      s_nxt.pwm_cnt = '0;
    else if (s_r.pwm_cnt >= per - CYC_W'(1))
      s_nxt.pwm_cnt = '0;
    else
      s_nxt.pwm_cnt = s_r.pwm_cnt + CYC_W'(1);
    // pulse centre sits at the phase offset from the period start
    s_nxt.center = s_r.en_s && per != '0 && s_r.pwm_cnt == phase_cyc(per, s_r.phase);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign config_done = s_r.done;
  assign track_mode = s_r.track;
  assign set_fault = s_r.set_fault;
  assign sync_fault = s_r.sync_fault;
  assign freq_valid = s_r.freq_valid;
  assign vout_target_mv = s_r.vout;
  assign output_divider_range = s_r.div_range;
  assign freq_khz = s_r.freq;
  assign bus_address = s_r.addr;
  assign current_sense_gain = s_r.gain;
  assign phase_deg = s_r.phase;
  assign sync_locked = s_r.locked;
  assign pwm_center = s_r.center;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_strap_once;
    s_r.done |=> $stable(s_r.track) && $stable(s_r.set_fault) && $stable(s_r.addr);
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("strap result changed");

  property p_set_open;
    !s_r.done && strap_ready && set_open && !vout_wr |=> s_r.vout == '0 && s_r.set_fault;
  endproperty
  a_set_open: assert property (p_set_open) else $error("open set strap not 0 V");

  property p_sync_open;
    !s_r.done && strap_ready && sync_open && !s_r.present && !freq_wr
      |=> s_r.freq == FREQ_FALLBACK_KHZ;
  endproperty
  a_sync_open: assert property (p_sync_open) else $error("open sync not fallback");

  property p_clock_at_strap;
    !s_r.done && strap_ready && s_r.present && !freq_wr |=> !s_r.freq_valid;
  endproperty
  a_clock_at_strap: assert property (p_clock_at_strap) else $error("freq stored under clock");

  property p_no_store_after_en;
    s_r.en_s && s_r.en_d && !freq_wr |=> $stable(s_r.freq);
  endproperty
  a_no_store_after_en: assert property (p_no_store_after_en) else $error("freq changed while on");

  property p_phase_locked;
    interleave_wr && s_r.en_s |=> $stable(s_r.phase);
  endproperty
  a_phase_locked: assert property (p_phase_locked) else $error("phase changed while on");

  property p_vout_range;
    vout_wr && vout_wr_mv < VOUT_MIN_MV && !(!s_r.done && strap_ready) |=> $stable(s_r.vout);
  endproperty
  a_vout_range: assert property (p_vout_range) else $error("low vout accepted");

  property p_vout_cap;
    s_r.en_s && s_r.en_d && $past(s_r.en_s) |-> s_r.vout <= limit_mv(s_r.div_range);
  endproperty
  a_vout_cap: assert property (p_vout_cap) else $error("vout over range cap");

  property p_loss;
    s_r.meas_cnt >= SYNC_TIMEOUT_CYC && !sync_rise |=> !s_r.present ##1 !s_r.locked;
  endproperty
  a_loss: assert property (p_loss) else $error("clock loss not seen");

  property p_center_zero;
    s_r.locked && sync_rise && s_r.phase == '0 && !interleave_wr && s_r.en_s
      ##1 s_r.locked && s_r.en_s && !sync_rise |=> s_r.center;
  endproperty
  a_center_zero: assert property (p_center_zero) else $error("centre not at edge");

  property p_addr_range;
    s_r.done |-> s_r.addr >= 7'(ADDR_BASE);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address below base");

  c_lock: cover property (!s_r.locked ##1 s_r.locked);
  c_center: cover property (s_r.locked && s_r.center);
  c_store_at_en: cover property (en_rise && s_r.present);
  c_strap_clock: cover property (!s_r.done && strap_ready && s_r.present);
endmodule : psic_config_core

// ===== bench/psic_sync_source.sv
// external sync clock source standing at the far side of the sync pin
`timescale 1ns/10ps
module psic_sync_source #(
  parameter int HALF = 100
) (
  input wire logic clk,
  input wire logic run,
  output logic sync_pin
);
  int cnt = 0;
  logic level = 1'b0;
  assign sync_pin = level;
  // fixed period, never retuned while running; idle low so no stray edge is seen
  always @(posedge clk) begin
    cnt <= (!run || cnt == HALF - 1) ? 0 : cnt + 1;
    if (!run) begin
      level <= 1'b0;
    end else if (cnt == HALF - 1) begin
      level <= ~level;
    end
  end
endmodule : psic_sync_source

// ===== bench/psic_config_core_bench.sv
// self-checking bench for the strap decode and sync lock block
`timescale 1ns/10ps
module psic_config_core_bench;
  import psic_pkg::*;
  logic clk = 0, reset_n = 0, strap_ready = 0, set_open = 0, sync_open = 0;
  logic enable_pin = 0, vout_wr = 0, freq_wr = 0, interleave_wr = 0, run = 0;
  logic [BAND_W-1:0] set_band = '0, sync_band = '0;
  logic [4:0] a_lo = '0;
  logic [2:0] a_hi = '0;
  logic [MV_W-1:0] vout_wr_mv = '0;
  logic [KHZ_W-1:0] freq_wr_khz = '0;
  logic [DEG_W-1:0] interleave_wr_deg = '0;
  logic config_done, track_mode, set_fault, sync_fault, freq_valid, sync_locked;
  logic pwm_center, sync_pin;
  logic [MV_W-1:0] vout_target_mv;
  logic [1:0] output_divider_range;
  logic [KHZ_W-1:0] freq_khz;
  logic [6:0] bus_address;
  logic [4:0] current_sense_gain;
  logic [DEG_W-1:0] phase_deg;
  int bad_count = 0, checked = 0, n = 0;
  int ph[8] = '{0, 60, 120, 180, 240, 300, 90, 270};
  int wv[8] = '{499, 500, 5251, 5250, 299, 300, 1001, 1000};
  int ex[8] = '{800, 500, 500, 5250, 1000, 300, 300, 1000};

  always #4 clk = ~clk;

  psic_sync_source u_psic_sync_source (.clk, .run, .sync_pin);
  psic_config_core u_psic_config_core (.clk, .reset_n, .strap_ready, .set_band,
    .set_open, .sync_band, .sync_open, .address_strap_low(a_lo),
    .address_strap_high(a_hi), .sync_pin, .enable_pin, .vout_wr, .vout_wr_mv,
    .freq_wr, .freq_wr_khz, .interleave_wr, .interleave_wr_deg, .config_done,
    .track_mode, .set_fault, .sync_fault, .freq_valid, .vout_target_mv,
    .output_divider_range, .freq_khz, .bus_address, .current_sense_gain,
    .phase_deg, .sync_locked, .pwm_center);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t value %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    #1;
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic end_test(input string nm);
    $display("test %s done, %0d checks, %0d errors", nm, checked, bad_count);
  endtask : end_test

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // full restart; straps are presented first, strap_ready raised wait_cyc+1 cycles after reset release
  task automatic power_up(input int wait_cyc);
    @(posedge clk);
    reset_n <= 1'b0;
    strap_ready <= 1'b0;
    enable_pin <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (wait_cyc + 1) @(posedge clk);
    strap_ready <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : power_up

  task automatic host_wr(input int k, input int v);
    @(posedge clk);
    vout_wr <= (k == 0);
    freq_wr <= (k == 1);
    interleave_wr <= (k == 2);
    vout_wr_mv <= MV_W'(v);
    freq_wr_khz <= KHZ_W'(v);
    interleave_wr_deg <= DEG_W'(v);
    @(posedge clk);
    vout_wr <= 1'b0;
    freq_wr <= 1'b0;
    interleave_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : host_wr

  task automatic set_en(input logic e);
    @(posedge clk);
    enable_pin <= e;
    repeat (8) @(posedge clk);
  endtask : set_en

  task automatic wait_center();
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (pwm_center !== 1'b1 && n < 400);
  endtask : wait_center

  task automatic strap_case(input logic [4:0] sb, input logic so, input logic [4:0] yb,
      input logic yo, input logic [4:0] lo, input logic [2:0] hi, input int mv,
      input logic tr, input logic sf, input int khz, input logic yf, input int ad,
      input int g);
    @(posedge clk);
    set_band <= sb;
    set_open <= so;
    sync_band <= yb;
    sync_open <= yo;
    a_lo <= lo;
    a_hi <= hi;
    power_up(0);
    chk(16'(vout_target_mv), 16'(mv));
    chk_bit(track_mode, tr);
    chk_bit(set_fault, sf);
    chk(16'(freq_khz), 16'(khz));
    chk_bit(sync_fault, yf);
    chk(16'(bus_address), 16'(ad));
    chk(16'(current_sense_gain), 16'(g));
    chk_bit(config_done, 1'b1);
    // straps move after capture; nothing may follow them
    @(posedge clk);
    set_band <= 5'd8;
    sync_band <= 5'd10;
    a_lo <= lo ^ 5'h01;
    repeat (4) @(posedge clk);
    chk(16'(vout_target_mv), 16'(mv));
    chk(16'(freq_khz), 16'(khz));
    chk(16'(bus_address), 16'(ad));
  endtask : strap_case

  initial begin
    #(400_000);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    strap_case(5'd4, 0, 5'd1, 0, 5'd3, 3'd1, 800, 0, 0, 300, 0, 'h25, 8);
    strap_case(5'd0, 0, 5'd0, 0, 5'd23, 3'd4, 0, 1, 0, 575, 0, 'h7F, 20);
    strap_case(5'd17, 0, 5'd16, 0, 5'd0, 3'd2, 0, 0, 0, 575, 0, 'h3A, 12);
    strap_case(5'd16, 1, 5'd5, 1, 5'd21, 3'd3, 0, 0, 1, 575, 1, 'h67, 16);
    strap_case(5'd16, 0, 5'd15, 0, 5'd20, 3'd4, 5000, 0, 0, 1000, 0, 'h7E, 20);
    end_test("straps");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      a_lo <= 5'(i);
      a_hi <= 3'd0;
      power_up(0);
      chk(16'(phase_deg), 16'(ph[(i + 2) % 8]));
    end
    end_test("phase defaults");
    @(posedge clk);
    set_band <= 5'd4;
    sync_band <= 5'd15;
    a_lo <= 5'd1;
    power_up(0);
    // host never crosses 475 kHz while enabled: all frequency writes happen disabled
    for (int i = 0; i < 8; i++) begin
      host_wr(i / 4, wv[i]);
      chk(i < 4 ? 16'(vout_target_mv) : 16'(freq_khz), 16'(ex[i]));
    end
    // 2000 mV before enable puts the middle divider range in force
    host_wr(0, 2000);
    host_wr(2, 180);
    chk(16'(phase_deg), 16'd180);
    end_test("host writes");
    run <= 1'b1;
    repeat (500) @(posedge clk);
    set_en(1'b1);
    chk(16'(freq_khz), 16'd625);
    chk_bit(freq_valid, 1'b1);
    chk(16'(output_divider_range), 16'd1);
    chk_bit(sync_locked, 1'b1);
    @(posedge sync_pin);
    wait_center();
    chk(16'(n), 16'd104);
    host_wr(0, 4000);
    chk(16'(vout_target_mv), 16'd3168);
    host_wr(0, 800);
    chk(16'(vout_target_mv), 16'd800);
    host_wr(2, 90);
    chk(16'(phase_deg), 16'd180);
    run <= 1'b0;
    repeat (600) @(posedge clk);
    chk_bit(sync_locked, 1'b1);
    repeat (400) @(posedge clk);
    chk_bit(sync_locked, 1'b0);
    chk(16'(freq_khz), 16'd625);
    wait_center();
    chk_bit(pwm_center, 1'b1);
    end_test("sync lock and loss");
    run <= 1'b1;
    power_up(500);
    chk_bit(freq_valid, 1'b0);
    chk(16'(freq_khz), 16'd0);
    set_en(1'b1);
    chk(16'(freq_khz), 16'd625);
    chk_bit(freq_valid, 1'b1);
    @(posedge clk);
    run <= 1'b0;
    sync_band <= 5'd3;
    // address 0x10 gives zero phase: centre lands right behind the sync edge
    a_lo <= 5'd6;
    power_up(20);
    set_en(1'b1);
    run <= 1'b1;
    repeat (500) @(posedge clk);
    chk_bit(sync_locked, 1'b1);
    chk(16'(freq_khz), 16'd400);
    chk(16'(phase_deg), 16'd0);
    @(posedge sync_pin);
    wait_center();
    chk(16'(n), 16'd4);
    end_test("clock timing at start-up");
    give_verdict();
  end
endmodule : psic_config_core_bench
